// ### core/sbc_irq_pkg.sv
package sbc_irq_pkg;

  // register addresses on the serial register port
  localparam logic [7:0] ADDR_SUMMARY      = 8'h50;
  localparam logic [7:0] ADDR_FLAGS_ONE    = 8'h51;
  localparam logic [7:0] ADDR_FLAGS_TWO    = 8'h52;
  localparam logic [7:0] ADDR_FLAGS_THREE  = 8'h53;
  localparam logic [7:0] ADDR_MASK_ONE     = 8'h56;
  localparam logic [7:0] ADDR_MASK_TWO     = 8'h57;
  localparam logic [7:0] ADDR_MASK_THREE   = 8'h58;
  localparam logic [7:0] ADDR_LINK_FLAGS   = 8'h5A;
  localparam logic [7:0] ADDR_LINK_MASK    = 8'h5E;

  // reset values
  localparam logic [7:0] RST_MASK_ONE      = 8'hB0;
  localparam logic [7:0] RST_MASK_TWO      = 8'h37;
  localparam logic [7:0] RST_MASK_THREE    = 8'hBC;
  localparam logic [7:0] RST_LINK_MASK     = 8'hCC;
  localparam logic [7:0] RST_FLAGS         = 8'h00;

  // implemented bits (others reserved, read zero)
  localparam logic [7:0] IMPL_MASK_ONE     = 8'hB0;
  localparam logic [7:0] IMPL_MASK_TWO     = 8'h37;
  localparam logic [7:0] IMPL_THREE        = 8'hBC;
  localparam logic [7:0] IMPL_LINK         = 8'hCC;

  // field positions, third flag register
  localparam int BIT_SERIAL_ERR    = 7;
  localparam int BIT_FAILSAFE      = 5;
  localparam int BIT_CHECKSUM_ERR  = 4;
  localparam int BIT_SUPPLY_SHORT  = 3;
  localparam int BIT_RESTART_LIMIT = 2;
  // field positions, link/switch flag register
  localparam int BIT_BUS_WAKE      = 7;
  localparam int BIT_BUS_TIMEOUT   = 6;
  localparam int BIT_SW_OVERCUR    = 3;
  localparam int BIT_SW_OPENLOAD   = 2;
  // summary register fields
  localparam int BIT_SUM_ANY       = 7;
  localparam int BIT_SUM_ONE       = 6;
  localparam int BIT_SUM_TWO       = 5;
  localparam int BIT_SUM_THREE     = 4;
  localparam int BIT_SUM_LINK      = 2;

endpackage : sbc_irq_pkg

// ### core/sbc_interrupt_flags_masks.sv
// Overview of operation
// - Bit 7 of the third flag register sets on a serial interface error and clears on a host write of one.
// - Bit 5 sets on fail-safe entry and a write of one clears it unless an entry event arrives in the same cycle.
// - Bit 4 sets on a frame checksum error and bit 3 on a supply short, both write-one-to-clear.
// - Bit 2 sets when the restart counter passes its limit and clears on a host write of one.
// - The first mask register holds enables at bits 7, 5 and 4, read-write, reset to enabled.
// - The second mask register holds enables at bits 5, 4, 2, 1 and 0, read-write, reset to enabled.
// - The third mask register holds enables at bits 7, 5, 4, 3 and 2, read-write, reset to enabled.
// - The link/switch flag register holds bus wake, bus timeout, over-current and open-load flags at 7, 6, 3, 2.
// - The link/switch mask register holds enables at bits 7, 6, 3 and 2, read-write, reset to enabled.
// - Each mask bit gates the flag at the same position, and a cleared enable keeps that flag off the interrupt.
// - Reserved bits read as zero and ignore writes.
// - The summary register shows the OR of all flags in bit 7 and per-register ORs beside it, read-only.
`timescale 1ns/100ps
module sbc_interrupt_flags_masks
  import sbc_irq_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // serial register port, one-cycle strobes
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // flag registers one and two, kept outside this block
  input  wire logic [7:0] flagsOne,
  input  wire logic [7:0] flagsTwo,
  // event pulses
  input  wire logic       serialErrorEvent,
  input  wire logic       failsafeEntryEvent,
  input  wire logic       checksumErrorEvent,
  input  wire logic       supplyShortEvent,
  input  wire logic       restartLimitEvent,
  input  wire logic       busWakeEvent,
  input  wire logic       busTimeoutEvent,
  input  wire logic       switchOvercurrentEvent,
  input  wire logic       switchOpenLoadEvent,
  // interrupt request, active high
  output logic            irqOut
);
  import sbc_irq_pkg::*;

  typedef struct packed {
    logic [7:0] maskOne;
    logic [7:0] maskTwo;
    logic [7:0] maskThree;
    logic [7:0] linkMask;
    logic [7:0] flagsThree;
    logic [7:0] linkFlags;
    logic [7:0] rdData;
    logic       irq;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // sticky flag update: set wins over write-one-to-clear
  function automatic logic [7:0] stickyFlags(input logic [7:0] cur, input logic [7:0] setVec,
                                             input logic wrHit, input logic [7:0] wd, input logic [7:0] impl);
    logic [7:0] clr;
    clr = wrHit ? wd : 8'h00;
    return ((cur & ~clr) | setVec) & impl;
  endfunction : stickyFlags

  logic [7:0] setThree;
  logic [7:0] setLink;
  logic [7:0] pendThree;
  logic [7:0] pendLink;
  logic [7:0] summary;
  logic       anyPend;

  always_comb
  begin
    setThree = 8'h00;
    setThree[BIT_SERIAL_ERR]    = serialErrorEvent;
    setThree[BIT_FAILSAFE]      = failsafeEntryEvent;
    setThree[BIT_CHECKSUM_ERR]  = checksumErrorEvent;
    setThree[BIT_SUPPLY_SHORT]  = supplyShortEvent;
    setThree[BIT_RESTART_LIMIT] = restartLimitEvent;
    setLink = 8'h00;
    setLink[BIT_BUS_WAKE]    = busWakeEvent;
    setLink[BIT_BUS_TIMEOUT] = busTimeoutEvent;
    setLink[BIT_SW_OVERCUR]  = switchOvercurrentEvent;
    setLink[BIT_SW_OPENLOAD] = switchOpenLoadEvent;
  end

  always_comb
  begin
    nxt_state = state_ff;
    // reserved bits masked off on write
    if (regWrite && regAddr == ADDR_MASK_ONE)
      nxt_state.maskOne = regWrData & IMPL_MASK_ONE;
    if (regWrite && regAddr == ADDR_MASK_TWO)
      nxt_state.maskTwo = regWrData & IMPL_MASK_TWO;
    if (regWrite && regAddr == ADDR_MASK_THREE)
      nxt_state.maskThree = regWrData & IMPL_THREE;
    if (regWrite && regAddr == ADDR_LINK_MASK)
      nxt_state.linkMask = regWrData & IMPL_LINK;
    nxt_state.flagsThree = stickyFlags(state_ff.flagsThree, setThree,
                                       regWrite && regAddr == ADDR_FLAGS_THREE,
                                       regWrData, IMPL_THREE);
    nxt_state.linkFlags = stickyFlags(state_ff.linkFlags, setLink,
                                      regWrite && regAddr == ADDR_LINK_FLAGS,
                                      regWrData, IMPL_LINK);
    // gate uses the registered flags so irq follows the readable state one cycle later
    nxt_state.irq = |(state_ff.flagsThree & state_ff.maskThree)
                  | |(state_ff.linkFlags & state_ff.linkMask)
                  | |(flagsOne & state_ff.maskOne)
                  | |(flagsTwo & state_ff.maskTwo);
    if (regRead)
    begin
      unique case (regAddr)
        ADDR_SUMMARY:     nxt_state.rdData = summary;
        ADDR_FLAGS_THREE: nxt_state.rdData = state_ff.flagsThree;
        ADDR_MASK_ONE:    nxt_state.rdData = state_ff.maskOne;
        ADDR_MASK_TWO:    nxt_state.rdData = state_ff.maskTwo;
        ADDR_MASK_THREE:  nxt_state.rdData = state_ff.maskThree;
        ADDR_LINK_FLAGS:  nxt_state.rdData = state_ff.linkFlags;
        ADDR_LINK_MASK:   nxt_state.rdData = state_ff.linkMask;
        default:          nxt_state.rdData = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    summary = 8'h00;
    summary[BIT_SUM_ONE]   = |flagsOne;
    summary[BIT_SUM_TWO]   = |flagsTwo;
    summary[BIT_SUM_THREE] = |state_ff.flagsThree;
    summary[BIT_SUM_LINK]  = |state_ff.linkFlags;
    summary[BIT_SUM_ANY]   = |summary[6:0];
    pendThree = state_ff.flagsThree & state_ff.maskThree;
    pendLink  = state_ff.linkFlags & state_ff.linkMask;
    anyPend   = |pendThree | |pendLink | |(flagsOne & state_ff.maskOne) | |(flagsTwo & state_ff.maskTwo);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff.maskOne    <= RST_MASK_ONE;
      state_ff.maskTwo    <= RST_MASK_TWO;
      state_ff.maskThree  <= RST_MASK_THREE;
      state_ff.linkMask   <= RST_LINK_MASK;
      state_ff.flagsThree <= RST_FLAGS;
      state_ff.linkFlags  <= RST_FLAGS;
      state_ff.rdData     <= 8'h00;
      state_ff.irq        <= 1'b0;
    end
    else
      state_ff <= nxt_state;
  end

  assign regRdData = state_ff.rdData;
  assign irqOut    = state_ff.irq;

  serial_err_set_a: assert property (@(posedge clock) disable iff (!rstn)
    serialErrorEvent |=> state_ff.flagsThree[BIT_SERIAL_ERR])
    else $error("serial error flag not set");
  failsafe_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_FLAGS_THREE && regWrData[BIT_FAILSAFE] && !failsafeEntryEvent
    |=> !state_ff.flagsThree[BIT_FAILSAFE])
    else $error("failsafe flag not cleared");
  checksum_set_a: assert property (@(posedge clock) disable iff (!rstn)
    checksumErrorEvent || supplyShortEvent |=> |state_ff.flagsThree[4:3])
    else $error("checksum or short flag missing");
  restart_set_a: assert property (@(posedge clock) disable iff (!rstn)
    restartLimitEvent |=> state_ff.flagsThree[BIT_RESTART_LIMIT])
    else $error("restart flag not set");
  mask_reserved_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_ff.maskOne & ~IMPL_MASK_ONE) == 8'h00 && (state_ff.maskTwo & ~IMPL_MASK_TWO) == 8'h00
    && (state_ff.flagsThree & ~IMPL_THREE) == 8'h00 && (state_ff.linkFlags & ~IMPL_LINK) == 8'h00
    && (state_ff.maskThree & ~IMPL_THREE) == 8'h00 && (state_ff.linkMask & ~IMPL_LINK) == 8'h00)
    else $error("reserved bit set");
  mask_write_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_LINK_MASK |=> state_ff.linkMask == ($past(regWrData) & IMPL_LINK))
    else $error("link mask write lost");
  set_beats_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    busWakeEvent && regWrite && regAddr == ADDR_LINK_FLAGS |=> state_ff.linkFlags[BIT_BUS_WAKE])
    else $error("set lost to clear");
  zero_write_keeps_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_LINK_FLAGS && regWrData == 8'h00
    |=> (state_ff.linkFlags & $past(state_ff.linkFlags)) == $past(state_ff.linkFlags))
    else $error("zero write changed flags");
  irq_follows_a: assert property (@(posedge clock) disable iff (!rstn)
    ##1 irqOut == $past(anyPend))
    else $error("irq does not follow enabled flags");
  summary_any_a: assert property (@(posedge clock) disable iff (!rstn)
    summary[BIT_SUM_ANY] == (|flagsOne || |flagsTwo || |state_ff.flagsThree || |state_ff.linkFlags))
    else $error("summary wrong");
  mask_one_write_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_MASK_ONE |=> state_ff.maskOne == ($past(regWrData) & IMPL_MASK_ONE))
    else $error("first mask write lost");
  mask_two_write_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_MASK_TWO |=> state_ff.maskTwo == ($past(regWrData) & IMPL_MASK_TWO))
    else $error("second mask write lost");
  three_mask_write_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_MASK_THREE |=> state_ff.maskThree == ($past(regWrData) & IMPL_THREE))
    else $error("third mask write lost");
  flags_three_set_a: assert property (@(posedge clock) disable iff (!rstn)
    |setThree |=> (state_ff.flagsThree & $past(setThree)) == $past(setThree))
    else $error("third register flag lost");
  link_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
    |setLink |=> (state_ff.linkFlags & $past(setLink)) == $past(setLink))
    else $error("link flag lost");
  // a set in the clearing cycle must survive, so only bits without a set are expected low
  link_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    regWrite && regAddr == ADDR_LINK_FLAGS
    |=> (state_ff.linkFlags & $past(regWrData) & ~$past(setLink)) == 8'h00)
    else $error("link flag not cleared");
  summary_read_a: assert property (@(posedge clock) disable iff (!rstn)
    regRead && regAddr == ADDR_SUMMARY |=> regRdData[BIT_SUM_ANY]
    == (|$past(flagsOne) || |$past(flagsTwo) || |$past(state_ff.flagsThree) || |$past(state_ff.linkFlags)))
    else $error("summary read wrong");
  irq_drop_a: assert property (@(posedge clock) disable iff (!rstn)
    irqOut && !anyPend |=> !irqOut)
    else $error("irq stays high without enabled flag");

endmodule : sbc_interrupt_flags_masks

// ### test/sbc_host_model.sv
`timescale 1ns/100ps
module sbc_host_model (
  // clock
  input  wire logic       clock,
  // serial register port
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // idle data shows the inverse so a stale value cannot pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    #1 d = regRdData;
  endtask : rd
endmodule : sbc_host_model

// ### test/sbc_interrupt_flags_masks_test.sv
`timescale 1ns/100ps
module sbc_interrupt_flags_masks_test;
  import sbc_irq_pkg::*;
  localparam logic [7:0] M_ADDR [4] = '{ADDR_MASK_ONE, ADDR_MASK_TWO, ADDR_MASK_THREE, ADDR_LINK_MASK};
  localparam logic [7:0] M_IMPL [4] = '{8'hB0, 8'h37, 8'hBC, 8'hCC};
  localparam int         EV_BIT [9] = '{7, 5, 4, 3, 2, 7, 6, 3, 2};
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic       regWrite, regRead, irqOut;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic [7:0] fOne = 8'h00;
  logic [7:0] fTwo = 8'h00;
  logic [8:0] ev = 9'h000;
  int         err_total = 0;
  int         n_compared = 0;
  always #10 clock = ~clock;
  sbc_host_model host (.clock(clock), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));
  sbc_interrupt_flags_masks dut (.clock(clock), .rstn(rstn), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .flagsOne(fOne), .flagsTwo(fTwo),
    .serialErrorEvent(ev[0]), .failsafeEntryEvent(ev[1]), .checksumErrorEvent(ev[2]),
    .supplyShortEvent(ev[3]), .restartLimitEvent(ev[4]), .busWakeEvent(ev[5]), .busTimeoutEvent(ev[6]),
    .switchOvercurrentEvent(ev[7]), .switchOpenLoadEvent(ev[8]), .irqOut(irqOut));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // irq lags the flag by a cycle, so three edges leave margin
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    settle;
  endtask : pulse
  task automatic t_masks;
    chk({7'h00, irqOut}, 8'h00, "irq after reset");
    for (int m = 0; m < 4; m++)
    begin
      host.rd(M_ADDR[m], rdv);
      chk(rdv, M_IMPL[m], "mask reset value");
      host.wr(M_ADDR[m], 8'h00);
      host.rd(M_ADDR[m], rdv);
      chk(rdv, 8'h00, "mask not cleared");
      host.wr(M_ADDR[m], 8'hFF);
      host.rd(M_ADDR[m], rdv);
      chk(rdv, M_IMPL[m], "reserved mask bits");
    end
    $display("test masks done");
  endtask : t_masks
  task automatic t_events;
    logic [7:0] b, a;
    int         m;
    for (int i = 0; i < 9; i++)
    begin
      b = 8'h01 << EV_BIT[i];
      a = (i < 5) ? ADDR_FLAGS_THREE : ADDR_LINK_FLAGS;
      m = (i < 5) ? 2 : 3;
      host.wr(M_ADDR[m], M_IMPL[m] & ~b);
      pulse(i);
      chk({7'h00, irqOut}, 8'h00, "masked flag raised irq");
      host.rd(a, rdv);
      chk(rdv, b, "flag not set");
      host.rd(ADDR_SUMMARY, rdv);
      chk(rdv, (i < 5) ? 8'h90 : 8'h84, "summary");
      host.wr(a, ~b);
      host.wr(M_ADDR[m], M_IMPL[m]);
      settle;
      chk({7'h00, irqOut}, 8'h01, "enabled flag no irq");
      host.wr(a, b);
      host.rd(a, rdv);
      chk(rdv, 8'h00, "flag not cleared");
      chk({7'h00, irqOut}, 8'h00, "irq stuck");
    end
    $display("test events done");
  endtask : t_events
  task automatic t_other;
    @(posedge clock);
    ev[1] <= 1'b1;
    host.wr(ADDR_FLAGS_THREE, 8'h20);
    ev[1] <= 1'b0;
    host.rd(ADDR_FLAGS_THREE, rdv);
    chk(rdv, 8'h20, "clear beat event");
    host.wr(ADDR_FLAGS_THREE, 8'h20);
    @(posedge clock);
    ev[5] <= 1'b1;
    host.wr(ADDR_LINK_FLAGS, 8'h80);
    ev[5] <= 1'b0;
    host.wr(ADDR_LINK_FLAGS, 8'h00);
    host.rd(ADDR_LINK_FLAGS, rdv);
    chk(rdv, 8'h80, "link clear beat event");
    host.wr(ADDR_LINK_FLAGS, 8'h80);
    host.rd(ADDR_LINK_FLAGS, rdv);
    chk(rdv, 8'h00, "link flag not cleared");
    fOne <= 8'h80;
    settle;
    chk({7'h00, irqOut}, 8'h01, "group one flag no irq");
    host.wr(ADDR_MASK_ONE, 8'h00);
    settle;
    chk({7'h00, irqOut}, 8'h00, "group one mask ignored");
    fTwo <= 8'h01;
    settle;
    chk({7'h00, irqOut}, 8'h01, "group two flag no irq");
    host.rd(ADDR_SUMMARY, rdv);
    chk(rdv, 8'hE0, "summary groups one and two");
    host.wr(ADDR_MASK_TWO, 8'h36);
    settle;
    chk({7'h00, irqOut}, 8'h00, "group two mask ignored");
    $display("test other done");
  endtask : t_other
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    t_masks;
    t_events;
    t_other;
    tally_and_finish;
  end
  initial
  begin
    #400000;
    err_total++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule : sbc_interrupt_flags_masks_test
